/* File: rtl/gauge_driver_spi_slave.sv */
// serial slave port of the dual gauge driver: framing, shift, latch
//
// Functional notes
// R1: output driver enabled only while select low
// R2: clock and data ignored while select high
// R3: select rise moves shifted word into register
// R4: master keeps serial clock low at select edges
// R5: input sampled on falling serial clock edge
// R6: output updated on rising serial clock edge
// R7: sixteen-bit words, most significant bit first
// R8: non-multiple-of-sixteen frames are discarded
// R9: master raises select between independent words
// R10: status first, then received bits pass through
// R11: first rising edge loads the status word
// R12: longer frames shift out data, keep last word
// R13: bits fifteen to thirteen select the register
// R14: master gives exactly sixteen clocks per word
// R15: master holds select high long enough
// R16: reset pin forces all logic to defaults
// R17: select rise synchronised before word is committed
`timescale 1ns/1ns

module gauge_driver_spi_slave #(
  parameter int WORD_W   = gauge_spi_pkg::WORD_W,
  parameter int DATA_W   = gauge_spi_pkg::DATA_W,
  parameter int NUM_REGS = gauge_spi_pkg::NUM_REGS
) (
  // system
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // serial link
  input  wire logic              spi_clk_i,
  input  wire logic              cs_b_i,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   so_oe_o,
  // core status word to return
  input  wire logic [WORD_W-1:0] status_i,
  // register contents
  output logic [DATA_W-1:0]      power_enable_calib_config_o,
  output logic [DATA_W-1:0]      max_velocity_o,
  output logic [DATA_W-1:0]      gauge0_position_o,
  output logic [DATA_W-1:0]      gauge1_position_o,
  output logic [DATA_W-1:0]      zero_return_command_o,
  output logic [DATA_W-1:0]      zero_return_config_o,
  output logic [DATA_W-1:0]      ramp_select_o,
  // frame events
  output logic [NUM_REGS-1:0]    reg_write_o,
  output logic                   test_write_o,
  output logic                   frame_drop_o
);

  // ----------------------------------------------------------------
  // link domain, falling edge: input shift and bit count
  // ----------------------------------------------------------------
  logic                              first_reg;
  logic [WORD_W-1:0]                 in_sh_reg;
  logic [gauge_spi_pkg::BCNT_W-1:0]  bcnt_reg;
  logic                              full_reg;
  logic                              frame_mark_reg;

  // marks the next falling edge as the first of a frame
  always_ff @(negedge spi_clk_i or posedge cs_b_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_reg <= 1'b1; // see R16
    end else if (cs_b_i) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  // shift register keeps its contents after select rises for capture
  always_ff @(negedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_sh_reg <= gauge_spi_pkg::WORD_ZERO; // see R16
    end else if (!cs_b_i) begin // see R2
      in_sh_reg <= {in_sh_reg[WORD_W-2:0], si_i}; // see R5 see R7
    end
  end

  // bit count modulo sixteen plus a flag for sixteen reached
  always_ff @(negedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_reg <= gauge_spi_pkg::BCNT_ZERO;
      full_reg <= 1'b0;
    end else if (!cs_b_i) begin // see R2
      if (first_reg) begin
        bcnt_reg <= gauge_spi_pkg::BCNT_ONE;
        full_reg <= 1'b0;
      end else begin
        bcnt_reg <= bcnt_reg + gauge_spi_pkg::BCNT_ONE;
        if (bcnt_reg == gauge_spi_pkg::BCNT_LAST) begin
          full_reg <= 1'b1;
        end
      end
    end
  end

  // flips on the first falling edge of each frame
  always_ff @(negedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_mark_reg <= 1'b0; // see R16
    end else if (!cs_b_i && first_reg) begin // see R2
      frame_mark_reg <= !frame_mark_reg;
    end
  end

  // ----------------------------------------------------------------
  // link domain, rising edge: output shift
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]                 st_sh_reg;
  logic [gauge_spi_pkg::RCNT_W-1:0]  rcnt_reg;
  logic                              so_reg;
  logic [WORD_W-1:0]                 status_hold_reg;

  // rising edges seen in this frame, saturating after the status word
  always_ff @(posedge spi_clk_i or posedge cs_b_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rcnt_reg <= gauge_spi_pkg::RCNT_ZERO;
    end else if (cs_b_i) begin // see R2
      rcnt_reg <= gauge_spi_pkg::RCNT_ZERO;
    end else if (rcnt_reg != gauge_spi_pkg::RCNT_STATUS) begin
      rcnt_reg <= rcnt_reg + gauge_spi_pkg::RCNT_ONE;
    end
  end

  // status word loaded on the first rising edge, then shifted
  always_ff @(posedge spi_clk_i or posedge cs_b_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_sh_reg <= gauge_spi_pkg::WORD_ZERO;
    end else if (cs_b_i) begin
      st_sh_reg <= gauge_spi_pkg::WORD_ZERO;
    end else if (rcnt_reg == gauge_spi_pkg::RCNT_ZERO) begin
      st_sh_reg <= {status_hold_reg[WORD_W-2:0], 1'b0}; // see R11
    end else begin
      st_sh_reg <= {st_sh_reg[WORD_W-2:0], 1'b0};
    end
  end

  // serial output bit: status first, then bits received sixteen ago
  always_ff @(posedge spi_clk_i or posedge cs_b_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      so_reg <= 1'b0;
    end else if (cs_b_i) begin
      so_reg <= 1'b0;
    end else if (rcnt_reg == gauge_spi_pkg::RCNT_ZERO) begin
      so_reg <= status_hold_reg[gauge_spi_pkg::MSB]; // see R6 see R11
    end else if (rcnt_reg == gauge_spi_pkg::RCNT_STATUS) begin
      so_reg <= in_sh_reg[gauge_spi_pkg::MSB]; // see R10 see R12
    end else begin
      so_reg <= st_sh_reg[gauge_spi_pkg::MSB]; // see R10
    end
  end

  assign so_o = so_reg;

  // ----------------------------------------------------------------
  // output enable: on within one clock of select low, off at once
  // ----------------------------------------------------------------
  logic so_oe_reg;

  always_ff @(posedge clk_i or posedge cs_b_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      so_oe_reg <= 1'b0;
    end else if (cs_b_i) begin
      so_oe_reg <= 1'b0; // see R1
    end else begin
      so_oe_reg <= 1'b1; // see R1
    end
  end

  assign so_oe_o = so_oe_reg;

  // ----------------------------------------------------------------
  // select synchroniser into the system clock
  // ----------------------------------------------------------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic cs_lvl_reg;
  logic cs_rise;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_b_i;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
    end
  end

  // level changes only once the last two stages agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_lvl_reg <= 1'b1;
    end else if (cs_s2_reg == cs_s3_reg) begin
      cs_lvl_reg <= cs_s3_reg; // see R17
    end
  end

  assign cs_rise = cs_s2_reg && cs_s3_reg && !cs_lvl_reg; // see R17

  // status frozen while a frame is in progress
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_hold_reg <= gauge_spi_pkg::WORD_ZERO;
    end else if (cs_lvl_reg && cs_s3_reg) begin
      status_hold_reg <= status_i;
    end
  end

  // ----------------------------------------------------------------
  // empty frame detection
  // ----------------------------------------------------------------
  logic mark_seen_reg;
  logic bits_seen;

  // marker as of the last select rise; no flip means no bits this frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mark_seen_reg <= 1'b0; // see R16
    end else if (cs_rise) begin
      mark_seen_reg <= frame_mark_reg; // see R8
    end
  end

  // a select pulse with no clocks must not replay the previous word
  assign bits_seen = frame_mark_reg != mark_seen_reg; // see R8

  // ----------------------------------------------------------------
  // frame check and address decode
  // ----------------------------------------------------------------
  logic                              frame_ok;
  logic [gauge_spi_pkg::ADDR_W-1:0]  wr_addr;
  logic [DATA_W-1:0]                 wr_data;

  // link words are still: serial clock is idle after select rises
  assign frame_ok = full_reg && (bcnt_reg == gauge_spi_pkg::BCNT_ZERO) && bits_seen; // see R8
  assign wr_addr  = in_sh_reg[gauge_spi_pkg::ADDR_HI:gauge_spi_pkg::ADDR_LO]; // see R13
  assign wr_data  = in_sh_reg[DATA_W-1:0];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]   reg_file_reg [NUM_REGS];
  logic [NUM_REGS-1:0] reg_write_reg;

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        reg_file_reg[i]  <= gauge_spi_pkg::REG_RESET; // see R16
        reg_write_reg[i] <= 1'b0;
      end else if (cs_rise && frame_ok &&
                   (wr_addr == gauge_spi_pkg::ADDR_W'(i))) begin
        reg_file_reg[i]  <= wr_data; // see R3 see R12 see R13
        reg_write_reg[i] <= 1'b1;
      end else begin
        reg_write_reg[i] <= 1'b0;
      end
    end
  end

  assign power_enable_calib_config_o =
    reg_file_reg[gauge_spi_pkg::ADDR_POWER_ENABLE_CALIB_CONFIG];
  assign max_velocity_o              =
    reg_file_reg[gauge_spi_pkg::ADDR_MAX_VELOCITY];
  assign gauge0_position_o           =
    reg_file_reg[gauge_spi_pkg::ADDR_GAUGE0_POSITION];
  assign gauge1_position_o           =
    reg_file_reg[gauge_spi_pkg::ADDR_GAUGE1_POSITION];
  assign zero_return_command_o       =
    reg_file_reg[gauge_spi_pkg::ADDR_ZERO_RETURN_COMMAND];
  assign zero_return_config_o        =
    reg_file_reg[gauge_spi_pkg::ADDR_ZERO_RETURN_CONFIG];
  assign ramp_select_o               =
    reg_file_reg[gauge_spi_pkg::ADDR_RAMP_SELECT];
  assign reg_write_o                 = reg_write_reg;

  // ----------------------------------------------------------------
  // test address and discarded frames
  // ----------------------------------------------------------------
  logic test_write_reg;
  logic frame_drop_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      test_write_reg <= 1'b0;
    end else begin
      test_write_reg <= cs_rise && frame_ok &&
                        (wr_addr == gauge_spi_pkg::ADDR_TEST_RESERVED); // see R13
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_drop_reg <= 1'b0;
    end else begin
      frame_drop_reg <= cs_rise && !frame_ok; // see R8
    end
  end

  assign test_write_o = test_write_reg;
  assign frame_drop_o = frame_drop_reg;

endmodule

/* File: rtl/gauge_spi_pkg.sv */
// constants for the gauge driver serial slave
package gauge_spi_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 13;
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 13;
  localparam int MSB     = WORD_W - 1;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_POWER_ENABLE_CALIB_CONFIG = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_MAX_VELOCITY              = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_GAUGE0_POSITION           = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_GAUGE1_POSITION           = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_RETURN_COMMAND       = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_RETURN_CONFIG        = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_RAMP_SELECT               = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_TEST_RESERVED             = 3'h7;
  localparam int                NUM_REGS                       = 7;

  // ----------------------------------------------------------------
  // reset values and counters
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET   = 13'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO   = 16'h0000;
  localparam int                BCNT_W      = 4;
  localparam logic [BCNT_W-1:0] BCNT_ZERO   = 4'h0;
  localparam logic [BCNT_W-1:0] BCNT_ONE    = 4'h1;
  localparam logic [BCNT_W-1:0] BCNT_LAST   = 4'hF;
  localparam int                RCNT_W      = 5;
  localparam logic [RCNT_W-1:0] RCNT_ZERO   = 5'h00;
  localparam logic [RCNT_W-1:0] RCNT_ONE    = 5'h01;
  localparam logic [RCNT_W-1:0] RCNT_STATUS = 5'h10;

endpackage

/* File: tb/gauge_driver_spi_slave_properties.sv */
// concurrent checks on the gauge serial slave ports
`timescale 1ns/1ns
module gauge_driver_spi_slave_properties #(
  parameter int DATA_W   = 13,
  parameter int NUM_REGS = 7
) (
  // system
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  // link
  input wire logic                cs_b_i,
  input wire logic                so_o,
  input wire logic                so_oe_o,
  // results
  input wire logic [DATA_W-1:0]   power_enable_calib_config_o,
  input wire logic [NUM_REGS-1:0] reg_write_o,
  input wire logic                test_write_o,
  input wire logic                frame_drop_o
);
  logic [NUM_REGS+1:0] ev;
  assign ev = {reg_write_o, test_write_o, frame_drop_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_oe_off; cs_b_i |-> !so_oe_o && !so_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  property p_oe_on; !cs_b_i ##1 !cs_b_i |-> so_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not enabled in frame");
  property p_quiet; cs_b_i [*8] |-> ev == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("event while deselected");
  property p_commit; $rose(cs_b_i) |-> ##[1:4] (|ev); endproperty
  a_commit: assert property (p_commit) else $error("no result after select rise");
  property p_after; |ev |-> cs_b_i && $past(cs_b_i, 2); endproperty
  a_after: assert property (p_after) else $error("event before select rise settled");
  property p_once; |ev |=> ev == '0; endproperty
  a_once: assert property (p_once) else $error("event longer than one cycle");
  property p_onehot; $onehot0(ev); endproperty
  a_onehot: assert property (p_onehot) else $error("more than one event");
  property p_hold; !$stable(power_enable_calib_config_o) |-> reg_write_o[0]; endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");
endmodule
bind gauge_driver_spi_slave gauge_driver_spi_slave_properties #(.DATA_W(DATA_W), .NUM_REGS(NUM_REGS)) u_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .power_enable_calib_config_o(power_enable_calib_config_o), .reg_write_o(reg_write_o),
  .test_write_o(test_write_o), .frame_drop_o(frame_drop_o));

/* File: tb/spi_host_model.sv */
// host master model for the serial link
`timescale 1ns/1ns
module spi_host_model (
  // link
  output logic      spi_clk_o,
  output logic      cs_b_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  initial begin
    spi_clk_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
  end
  // n bits of w msb first, 125 ns clock only inside the frame
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rx);
    rx = '0;
    cs_b_o = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = w[i];
      #20;
      spi_clk_o = 1'b1;
      #62;
      spi_clk_o = 1'b0;
      rx = {rx[46:0], so_oe_i ? so_i : 1'bx};
      #43;
    end
    cs_b_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule

/* File: tb/tb_gauge_driver_spi_slave.sv */
// self-checking bench for the gauge serial slave
`timescale 1ns/1ns
module tb_gauge_driver_spi_slave;
  logic        clk_i, rst_b_i, spi_clk, cs_b, si, so_o, so_oe_o;
  logic        test_write_o, frame_drop_o;
  logic [15:0] status_i;
  logic [12:0] r[7];
  logic [12:0] exp_r[7];
  logic [6:0]  reg_write_o;
  logic [47:0] rx;
  logic [8:0]  ev;
  logic [31:0] seed;
  int          n_fail, num_checks;
  int          lens[7] = '{0, 1, 15, 17, 31, 32, 48};

  gauge_driver_spi_slave dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .spi_clk_i(spi_clk), .cs_b_i(cs_b), .si_i(si),
    .so_o(so_o), .so_oe_o(so_oe_o), .status_i(status_i),
    .power_enable_calib_config_o(r[0]), .max_velocity_o(r[1]), .gauge0_position_o(r[2]),
    .gauge1_position_o(r[3]), .zero_return_command_o(r[4]), .zero_return_config_o(r[5]),
    .ramp_select_o(r[6]), .reg_write_o(reg_write_o), .test_write_o(test_write_o),
    .frame_drop_o(frame_drop_o));
  spi_host_model host (.spi_clk_o(spi_clk), .cs_b_o(cs_b), .si_o(si), .so_i(so_o), .so_oe_i(so_oe_o));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // status first, then the bits sent, in arrival order
  function automatic logic [47:0] exp_rx(logic [15:0] st, logic [47:0] w, int n);
    exp_rx = '0;
    for (int k = 0; k < n; k++)
      exp_rx[n-1-k] = (k < 16) ? st[15-k] : w[n-k+15];
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic frame(input logic [47:0] w, input int n);
    logic [8:0] want;
    int         t;
    host.xfer(w, n, rx);
    check(rx, exp_rx(status_i, w, n));
    if (n % 16 != 0 || n == 0)
      want = 9'h001;
    else if (w[15:13] == 3'h7)
      want = 9'h002;
    else begin
      want = 9'h004 << w[15:13];
      exp_r[w[15:13]] = w[12:0];
    end
    ev = '0;
    t = 0;
    while (ev == '0 && t < 8) begin
      @(negedge clk_i);
      ev = {reg_write_o, test_write_o, frame_drop_o};
      t++;
    end
    check(48'(ev), 48'(want));
    if (ev == '0)
      print_verdict();
    for (int i = 0; i < 7; i++)
      check(48'(r[i]), 48'(exp_r[i]));
    status_i = 16'(rnd());
    repeat (5) @(negedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    seed = 32'h2537BB3A;
    rst_b_i = 1'b0;
    status_i = 16'hA5C3;
    n_fail = 0;
    num_checks = 0;
    foreach (exp_r[i]) exp_r[i] = '0;
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    for (int a = 0; a < 8; a++)
      frame({32'h0, 3'(a), 13'(rnd())}, 16);
    foreach (lens[j])
      frame(48'({rnd(), rnd()}), lens[j]);
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    foreach (exp_r[i]) exp_r[i] = '0;
    for (int i = 0; i < 7; i++)
      check(48'(r[i]), 48'(exp_r[i]));
    check(48'(so_oe_o), 48'h0);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    frame({32'h0, 16'(rnd())}, 16);
    print_verdict();
  end
endmodule
